// file: frs_pkg.sv
package frs_pkg;

  // I/O addresses
  localparam logic [15:0] FRS_RATE_CTRL_ADDR  = 16'h03F7;
  localparam logic [15:0] FRS_DATA_ADDR       = 16'h03F5;

  // Rate control field layout
  localparam int          FRS_RATE_LSB        = 0;
  localparam int          FRS_NO_PRECOMP_FLAG_BIT      = 2;
  localparam logic [1:0]  FRS_RATE_RESET      = 2'h2;
  localparam logic        FRS_NO_PRECOMP_FLAG_RESET    = 1'b0;

  // Interface modes
  typedef enum logic [1:0] {
    FRS_MODE_AT      = 2'b00,
    FRS_MODE_ALT     = 2'b01,
    FRS_MODE_STD2    = 2'b10,
    FRS_MODE_COMPACT = 2'b11
  } frs_mode_t;

  // Termination codes
  localparam logic [1:0]  FRS_TERM_NORMAL     = 2'h0;
  localparam logic [1:0]  FRS_TERM_FAILED     = 2'h1;
  localparam logic [1:0]  FRS_TERM_INVALID    = 2'h2;
  localparam logic [1:0]  FRS_TERM_POLLING    = 2'h3;

  // Status field positions
  localparam int          FRS_S0_TERM_LSB     = 6;
  localparam int          FRS_S0_SEEK_BIT     = 5;
  localparam int          FRS_S0_EQUIP_BIT    = 4;
  localparam int          FRS_S0_HEAD_BIT     = 2;
  localparam int          FRS_S1_END_BIT      = 7;
  localparam int          FRS_S1_CRC_BIT      = 5;
  localparam int          FRS_S1_OVR_BIT      = 4;
  localparam int          FRS_S1_NODATA_BIT   = 2;
  localparam int          FRS_S1_WP_BIT       = 1;
  localparam int          FRS_S1_MARK_BIT     = 0;

  // Media limits
  localparam logic [6:0]  FRS_RECAL_STEPS     = 7'h50;
  localparam logic [7:0]  FRS_LAST_SECTOR     = 8'hFF;

endpackage

// file: frs_status_unit.sv
`timescale 1ns/1ps
module frs_status_unit
  import frs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       soft_reset_i,
  input  wire logic       cmd_start_i,
  input  wire logic       write_cmd_i,
  input  wire logic       recal_step_i,
  input  wire logic       track_zero_i,
  input  wire logic       write_protect_i,
  input  wire logic       ev_crc_i,
  input  wire logic       ev_overrun_i,
  input  wire logic       ev_no_data_i,
  input  wire logic       ev_no_mark_i,
  input  wire logic       ev_past_zero_i,
  input  wire logic       ev_end_track_i,
  output logic            equip_fault_o,
  output logic [7:0]      s1_flags_o
);

  logic [6:0] step_cnt_r;
  logic       equip_r;
  logic [7:0] s1_r;
  logic       recal_fail;

  // The last allowed step without track zero is a one-cycle event, so a count left
  // standing at its limit cannot set the flag again once a new command clears it
  assign recal_fail = recal_step_i && step_cnt_r == FRS_RECAL_STEPS - 7'h01 && !track_zero_i;

  assign equip_fault_o = equip_r;
  assign s1_flags_o    = s1_r;

  // Recalibrate step counter: give up after the fixed number of steps
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      step_cnt_r <= 7'h00;
    end else if (soft_reset_i || cmd_start_i || track_zero_i) begin
      step_cnt_r <= 7'h00;
    end else if (recal_step_i && step_cnt_r != FRS_RECAL_STEPS) begin
      step_cnt_r <= step_cnt_r + 7'h01;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      equip_r <= 1'b0;
    end else if (recal_fail || ev_past_zero_i) begin
      equip_r <= 1'b1; // R9
    end else if (soft_reset_i || cmd_start_i) begin
      equip_r <= 1'b0;
    end
  end

  // Sticky per-command error flags; a set beats the clear of a new command
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_r <= 8'h00;
    end else begin
      if (soft_reset_i || cmd_start_i) begin
        s1_r <= 8'h00;
      end
      if (ev_end_track_i) begin
        s1_r[FRS_S1_END_BIT] <= 1'b1; // R11
      end
      if (ev_crc_i) begin
        s1_r[FRS_S1_CRC_BIT] <= 1'b1; // R12
      end
      if (ev_overrun_i) begin
        s1_r[FRS_S1_OVR_BIT] <= 1'b1; // R13
      end
      if (ev_no_data_i) begin
        s1_r[FRS_S1_NODATA_BIT] <= 1'b1; // R14
      end
      if (write_cmd_i && write_protect_i) begin
        s1_r[FRS_S1_WP_BIT] <= 1'b1; // R15
      end
      if (ev_no_mark_i) begin
        s1_r[FRS_S1_MARK_BIT] <= 1'b1; // R16
      end
    end
  end

endmodule

// file: frs_rate_status.sv
`timescale 1ns/1ps
// How it works
// (R1) Base modes: write-only rate register at 3F7, bits 1:0 rate, reset to 10.
// (R2) Host writes zeros to reserved rate-register bits.
// (R3) Compact mode: bit 2 stores no-precomp flag, read back on input register bit 2.
// (R4) No-precomp flag survives software reset.
// (R5) Density output high on hardware reset, untouched by software resets.
// (R6) Result phase: data register returns status bytes of the last command.
// (R7) Status 0 bits 7:6 hold termination code 00/01/10/11.
// (R8) Status 0 bit 5 set when seek, relative seek or recalibrate completes.
// (R9) Status 0 bit 4: recal 80 steps without track zero, or seek past zero.
// (R10) Status 0 bit 2 head, bits 1:0 drive, bit 3 zero.
// (R11) Status 1 bit 7: past last sector 255, or data command ends without count.
// (R12) Status 1 bit 5: CRC error in ID or data field.
// (R13) Status 1 bit 4: overrun or underrun of data service.
// (R14) Status 1 bit 2: sector not found, ID unreadable, or bad sector sequence.
// (R15) Status 1 bit 1: write-protect high during a write or format command.
// (R16) Status 1 bit 0: no ID mark after two index pulses, or no data mark.
// (R17) Status 1 bits 6 and 3 always zero.
// (R18) Hardware reset gives 250 Kbps rate; software reset keeps it.
// (R19) Register layout follows the interface mode bits.
// (R20) Rate register writes update the shared data-rate state.
module frs_rate_status
  import frs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       soft_reset_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       io_wr_i,
  input  wire logic       io_rd_i,
  input  wire logic [15:0] io_addr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic [7:0]      io_rdata_o,
  input  wire logic       rate_sel_wr_i,
  input  wire logic [1:0] rate_sel_wdata_i,
  output logic [1:0]      data_rate_o,
  output logic            no_precomp_flag_o,
  output logic            density_select_out_o,
  input  wire logic       track_zero_in_i,
  input  wire logic       write_protect_in_i,
  input  wire logic       index_pulse_in_i,
  input  wire logic       cmd_start_i,
  input  wire logic       cmd_done_i,
  input  wire logic [1:0] termination_code_i,
  input  wire logic       seek_cmd_i,
  input  wire logic       write_cmd_i,
  input  wire logic       data_cmd_i,
  input  wire logic       terminal_count_i,
  input  wire logic       recal_step_i,
  input  wire logic       head_i,
  input  wire logic [1:0] drive_selected_i,
  input  wire logic [7:0] sector_num_i,
  input  wire logic       sector_advance_i,
  input  wire logic       id_mark_found_i,
  input  wire logic       data_mark_missing_i,
  input  wire logic       ev_crc_i,
  input  wire logic       ev_overrun_i,
  input  wire logic       ev_no_data_i,
  input  wire logic       ev_past_zero_i,
  input  wire logic       result_phase_i,
  input  wire logic       result_index_i,
  output logic            result_read_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] trk_sync_r;
  logic [1:0] wp_sync_r;
  logic [1:0] idx_sync_r;
  logic       idx_prev_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      trk_sync_r <= 2'h0;
      wp_sync_r  <= 2'h0;
      idx_sync_r <= 2'h3;
      idx_prev_r <= 1'b1;
    end else begin
      trk_sync_r <= {trk_sync_r[0], track_zero_in_i};
      wp_sync_r  <= {wp_sync_r[0], write_protect_in_i};
      idx_sync_r <= {idx_sync_r[0], index_pulse_in_i};
      idx_prev_r <= idx_sync_r[1];
    end
  end

  logic track_zero;
  logic write_prot;
  logic index_edge;

  assign track_zero = trk_sync_r[1];
  assign write_prot = wp_sync_r[1];
  // Index input is active low: a falling edge marks the index hole
  assign index_edge = idx_prev_r && !idx_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Rate control register
  frs_mode_t  mode;
  logic       rate_wr;
  logic [1:0] rate_r;
  logic       no_precomp_flag_r;
  logic       dens_r;

  assign mode    = frs_mode_t'(mode_i);
  assign rate_wr = io_wr_i && io_addr_i == FRS_RATE_CTRL_ADDR; // R1

  // Only a hardware reset restores the rate; soft resets are ignored here
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rate_r <= FRS_RATE_RESET; // R18
    end else if (rate_wr) begin
      rate_r <= io_wdata_i[FRS_RATE_LSB +: 2]; // R1
    end else if (rate_sel_wr_i) begin
      rate_r <= rate_sel_wdata_i; // R20
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      no_precomp_flag_r <= FRS_NO_PRECOMP_FLAG_RESET;
    end else if (rate_wr && mode == FRS_MODE_COMPACT) begin
      no_precomp_flag_r <= io_wdata_i[FRS_NO_PRECOMP_FLAG_BIT]; // R3 R4 R19
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dens_r <= 1'b1; // R5
    end else begin
      dens_r <= 1'b1;
    end
  end

  assign data_rate_o          = rate_r; // R20
  assign no_precomp_flag_o    = no_precomp_flag_r; // R3
  assign density_select_out_o = dens_r; // R5

  ////////////////////////////////////////////////////////////////////////////
  // Result byte 0 state
  logic [1:0] term_r;
  logic       seek_done_r;
  logic       head_r;
  logic [1:0] drv_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      term_r <= FRS_TERM_NORMAL;
      head_r <= 1'b0;
      drv_r  <= 2'h0;
    end else if (soft_reset_i) begin
      term_r <= FRS_TERM_NORMAL;
      head_r <= 1'b0;
      drv_r  <= 2'h0;
    end else if (cmd_done_i) begin
      term_r <= termination_code_i; // R7
      head_r <= head_i; // R10
      drv_r  <= drive_selected_i; // R10
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      seek_done_r <= 1'b0;
    end else if (cmd_done_i && seek_cmd_i) begin
      seek_done_r <= 1'b1; // R8
    end else if (soft_reset_i || cmd_start_i) begin
      seek_done_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Media event detection
  logic [1:0] idx_cnt_r;
  logic       no_id_mark;
  logic       end_track;

  // Two index pulses without an ID mark means the mark is missing
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx_cnt_r <= 2'h0;
    end else if (soft_reset_i || cmd_start_i || id_mark_found_i) begin
      idx_cnt_r <= 2'h0;
    end else if (index_edge && idx_cnt_r != 2'h2) begin
      idx_cnt_r <= idx_cnt_r + 2'h1;
    end
  end

  // Fires once, on the second index edge, so a stale count cannot re-arm the flag
  assign no_id_mark = (index_edge && idx_cnt_r == 2'h1) || data_mark_missing_i; // R16
  assign end_track  = (sector_advance_i && sector_num_i == FRS_LAST_SECTOR) ||
                      (cmd_done_i && data_cmd_i && !terminal_count_i); // R11

  logic       equip_fault;
  logic [7:0] s1_flags;

  frs_status_unit u_status (
    .clk_i           (clk_i),
    .reset_i         (reset_i),
    .soft_reset_i    (soft_reset_i),
    .cmd_start_i     (cmd_start_i),
    .write_cmd_i     (write_cmd_i),
    .recal_step_i    (recal_step_i),
    .track_zero_i    (track_zero),
    .write_protect_i (write_prot),
    .ev_crc_i        (ev_crc_i),
    .ev_overrun_i    (ev_overrun_i),
    .ev_no_data_i    (ev_no_data_i),
    .ev_no_mark_i    (no_id_mark),
    .ev_past_zero_i  (ev_past_zero_i),
    .ev_end_track_i  (end_track),
    .equip_fault_o   (equip_fault),
    .s1_flags_o      (s1_flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result byte assembly and read port
  logic [7:0] status0;
  logic [7:0] status1;
  logic [7:0] dir_byte;
  logic       data_rd;

  always_comb begin
    status0                            = 8'h00; // R10
    status0[FRS_S0_TERM_LSB +: 2]      = term_r; // R7
    status0[FRS_S0_SEEK_BIT]           = seek_done_r; // R8
    status0[FRS_S0_EQUIP_BIT]          = equip_fault; // R9
    status0[FRS_S0_HEAD_BIT]           = head_r; // R10
    status0[1:0]                       = drv_r; // R10
  end

  always_comb begin
    status1                            = 8'h00; // R17
    status1[FRS_S1_END_BIT]            = s1_flags[FRS_S1_END_BIT];
    status1[FRS_S1_CRC_BIT]            = s1_flags[FRS_S1_CRC_BIT];
    status1[FRS_S1_OVR_BIT]            = s1_flags[FRS_S1_OVR_BIT];
    status1[FRS_S1_NODATA_BIT]         = s1_flags[FRS_S1_NODATA_BIT];
    status1[FRS_S1_WP_BIT]             = s1_flags[FRS_S1_WP_BIT];
    status1[FRS_S1_MARK_BIT]           = s1_flags[FRS_S1_MARK_BIT];
  end

  // Compact mode input register view carries the stored flag
  always_comb begin
    dir_byte = 8'h00;
    if (mode == FRS_MODE_COMPACT) begin
      dir_byte[FRS_NO_PRECOMP_FLAG_BIT] = no_precomp_flag_r; // R3 R19
      dir_byte[1:0]            = rate_r;
    end
  end

  assign data_rd       = io_rd_i && io_addr_i == FRS_DATA_ADDR;
  assign result_read_o = data_rd && result_phase_i;

  logic [7:0] rdata_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 8'h00;
    end else if (result_read_o) begin
      rdata_r <= result_index_i ? status1 : status0; // R6
    end else if (io_rd_i && io_addr_i == FRS_RATE_CTRL_ADDR) begin
      rdata_r <= dir_byte;
    end
  end

  assign io_rdata_o = rdata_r;

endmodule

// file: frs_rate_status_chk.sv
`timescale 1ns/1ps
module frs_rate_status_chk
  import frs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        soft_reset_i,
  input wire logic [1:0]  mode_i,
  input wire logic        io_wr_i,
  input wire logic        io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0]  io_wdata_i,
  input wire logic [7:0]  io_rdata_o,
  input wire logic        rate_sel_wr_i,
  input wire logic [1:0]  rate_sel_wdata_i,
  input wire logic [1:0]  data_rate_o,
  input wire logic        no_precomp_flag_o,
  input wire logic        density_select_out_o,
  input wire logic        result_phase_i,
  input wire logic        result_index_i,
  input wire logic        result_read_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic       hit_w;
  logic [7:0] wd_r;
  logic [1:0] rs_r;
  assign hit_w = io_wr_i && io_addr_i == FRS_RATE_CTRL_ADDR;
  // Last cycle's write data, compared after the one-cycle update
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wd_r <= 8'h00;
      rs_r <= 2'h0;
    end else begin
      wd_r <= io_wdata_i;
      rs_r <= rate_sel_wdata_i;
    end
  end
  ////////////////////////////////////////
  density_high_a: assert property (density_select_out_o)
    else $error("density output low");
  rate_write_a: assert property (hit_w |=> data_rate_o == wd_r[1:0])
    else $error("rate write lost");
  no_precomp_flag_base_a: assert property (hit_w && mode_i != FRS_MODE_COMPACT |=> $stable(no_precomp_flag_o))
    else $error("flag written outside compact mode");
  no_precomp_flag_store_a: assert property (hit_w && mode_i == FRS_MODE_COMPACT |=> no_precomp_flag_o == wd_r[2])
    else $error("flag not stored");
  soft_keep_a: assert property (soft_reset_i && !hit_w && !rate_sel_wr_i |=>
    $stable(data_rate_o) && $stable(no_precomp_flag_o))
    else $error("soft reset changed rate state");
  rate_path_a: assert property (rate_sel_wr_i && !hit_w |=> data_rate_o == rs_r)
    else $error("shared rate path lost");
  result_strobe_a: assert property (result_read_o == (io_rd_i && io_addr_i == FRS_DATA_ADDR && result_phase_i))
    else $error("result read strobe wrong");
  s0_zero_bit_a: assert property (result_read_o && !result_index_i |=> !io_rdata_o[3])
    else $error("status0 bit3 set");
  s1_zero_bits_a: assert property (result_read_o && result_index_i |=> !io_rdata_o[6] && !io_rdata_o[3])
    else $error("status1 unused bit set");
  read_hold_a: assert property (io_rd_i && !result_read_o && io_addr_i != FRS_RATE_CTRL_ADDR |=>
    $stable(io_rdata_o))
    else $error("read data changed on unmapped read");
  cover property (hit_w && mode_i == FRS_MODE_COMPACT);
  cover property (result_read_o && result_index_i);
  cover property (soft_reset_i);
endmodule

// file: frs_host.sv
`timescale 1ns/1ps
module frs_host
  import frs_pkg::*;
(
  input  wire logic [1:0]  mode_i,
  input  wire logic        clk_i,
  input  wire logic [7:0]  io_rdata_o,
  output logic             io_wr_i,
  output logic             io_rd_i,
  output logic [15:0]      io_addr_i,
  output logic [7:0]       io_wdata_i
);
  initial begin
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
    io_addr_i = 16'h0000;
    io_wdata_i = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_wr_i <= 1'b1;
    io_addr_i <= a;
    io_wdata_i <= d & ((mode_i == FRS_MODE_COMPACT) ? 8'h07 : 8'h03);
    @(posedge clk_i);
    io_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    io_rd_i <= 1'b1;
    io_addr_i <= a;
    @(posedge clk_i);
    io_rd_i <= 1'b0;
    #1 d = io_rdata_o;
  endtask
endmodule

// file: frs_rate_status_bench.sv
`timescale 1ns/1ps
module frs_rate_status_bench
  import frs_pkg::*;
  ;
  logic        clk_i, reset_i, soft_reset_i, rate_sel_wr_i, cmd_start_i, cmd_done_i, io_wr_i, io_rd_i;
  logic        track_zero_in_i, write_protect_in_i, index_pulse_in_i, seek_cmd_i, write_cmd_i;
  logic        data_cmd_i, terminal_count_i, recal_step_i, head_i, sector_advance_i, ev_past_zero_i;
  logic        id_mark_found_i, data_mark_missing_i, ev_crc_i, ev_overrun_i, ev_no_data_i;
  logic        result_phase_i, result_index_i, no_precomp_flag_o, density_select_out_o, result_read_o;
  logic [1:0]  mode_i, rate_sel_wdata_i, data_rate_o, termination_code_i, drive_selected_i;
  logic [15:0] io_addr_i;
  logic [7:0]  io_wdata_i, io_rdata_o, sector_num_i, got;
  logic [6:0]  evv;
  logic        idx_en;
  logic [7:0]  e1 [7] = '{8'h01, 8'h04, 8'h10, 8'h20, 8'h00, 8'h80, 8'h02};
  int          n_fail, checks, cyc;
  assign {write_protect_in_i, sector_advance_i, ev_past_zero_i, ev_crc_i, ev_overrun_i, ev_no_data_i,
          data_mark_missing_i} = evv;
  frs_rate_status uut (.*);
  frs_host host (.*);
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Index pin, active low: one low cycle after each step pulse while enabled
  always @(posedge clk_i) begin
    index_pulse_in_i <= !(idx_en && recal_step_i);
  end
  ////////////////////////////////////////
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ctl(input logic [7:0] e);
    #1 cmp("control", e, {4'h0, density_select_out_o, no_precomp_flag_o, data_rate_o});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One command: start, optional recal steps, event pulse, done, then both result bytes
  task automatic cmd(input logic [1:0] tc, input logic [6:0] v, input int n, input logic [7:0] e0,
                     input logic [7:0] s1);
    @(posedge clk_i);
    cmd_start_i <= 1'b1;
    termination_code_i <= tc;
    @(posedge clk_i);
    cmd_start_i <= 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      recal_step_i <= 1'b1;
      @(posedge clk_i);
      recal_step_i <= 1'b0;
    end
    @(posedge clk_i);
    evv <= v;
    @(posedge clk_i);
    evv <= 7'h00;
    repeat (4) @(posedge clk_i);
    cmd_done_i <= 1'b1;
    @(posedge clk_i);
    cmd_done_i <= 1'b0;
    result_phase_i <= 1'b1;
    result_index_i <= 1'b0;
    host.rd(FRS_DATA_ADDR, got);
    cmp("status0", e0, got);
    @(posedge clk_i);
    result_index_i <= 1'b1;
    host.rd(FRS_DATA_ADDR, got);
    cmp("status1", s1, got);
    @(posedge clk_i);
    result_phase_i <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end
  ////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    {soft_reset_i, rate_sel_wr_i, cmd_start_i, cmd_done_i, track_zero_in_i, seek_cmd_i, write_cmd_i,
     data_cmd_i, terminal_count_i, recal_step_i, head_i, id_mark_found_i, result_phase_i} = '0;
    {result_index_i, mode_i, rate_sel_wdata_i, termination_code_i, drive_selected_i} = '0;
    {sector_num_i, evv, idx_en, n_fail, checks} = '0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    ctl(8'h0A);
    @(posedge clk_i);
    mode_i <= FRS_MODE_COMPACT;
    host.wr(FRS_RATE_CTRL_ADDR, 8'hFF);
    ctl(8'h0F);
    host.rd(FRS_RATE_CTRL_ADDR, got);
    cmp("readback", 8'h07, got);
    @(posedge clk_i);
    mode_i <= FRS_MODE_AT;
    host.wr(FRS_RATE_CTRL_ADDR, 8'h05);
    ctl(8'h0D);
    host.rd(FRS_RATE_CTRL_ADDR, got);
    cmp("readback", 8'h00, got);
    @(posedge clk_i);
    rate_sel_wr_i <= 1'b1;
    @(posedge clk_i);
    rate_sel_wr_i <= 1'b0;
    ctl(8'h0C);
    @(posedge clk_i);
    soft_reset_i <= 1'b1;
    @(posedge clk_i);
    soft_reset_i <= 1'b0;
    ctl(8'h0C);
    $display("test rate register done");
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      seek_cmd_i <= k[0];
      head_i <= k[1];
      drive_selected_i <= 2'(3 - k);
      cmd(2'(k), 7'h00, 0, {2'(k), k[0], 2'h0, k[1], 2'(3 - k)}, 8'h00);
    end
    $display("test status0 done");
    @(posedge clk_i);
    seek_cmd_i <= 1'b1;
    {head_i, drive_selected_i} <= 3'h0;
    cmd(FRS_TERM_FAILED, 7'h00, 79, 8'h60, 8'h00);
    cmd(FRS_TERM_FAILED, 7'h00, 80, 8'h70, 8'h00);
    $display("test recalibrate done");
    @(posedge clk_i);
    seek_cmd_i <= 1'b0;
    write_cmd_i <= 1'b1;
    sector_num_i <= FRS_LAST_SECTOR;
    foreach (e1[j]) cmd(FRS_TERM_FAILED, 7'(1 << j), 0, {3'h2, 1'(j == 4), 4'h0}, e1[j]);
    idx_en <= 1'b1;
    cmd(FRS_TERM_FAILED, 7'h00, 2, 8'h40, 8'h01);
    idx_en <= 1'b0;
    @(posedge clk_i);
    write_cmd_i <= 1'b0;
    data_cmd_i <= 1'b1;
    cmd(FRS_TERM_NORMAL, 7'h00, 0, 8'h00, 8'h80);
    host.rd(16'h03F0, got);
    cmp("unmapped", 8'h80, got);
    @(posedge clk_i);
    terminal_count_i <= 1'b1;
    cmd(FRS_TERM_NORMAL, 7'h00, 0, 8'h00, 8'h00);
    $display("test status1 done");
    close_out();
  end
endmodule
bind frs_rate_status frs_rate_status_chk chk (.*);
